// *** verilog/gpdp_top.sv ***
// GPIO port data registers for ports A and B and the port B and port A pins 12..15 pull-up disable controls.
// Assumes mux, direction and set/clear/invert strobes come from
// neighbouring logic on the same system clock; pin levels arrive asynchronously.
`timescale 1ns/10ps
`default_nettype none

module gpdp_top #(
    // Selects the product variant whose port A pins 12..15 pull-ups start off
    parameter bit PA_HI_PULLUP_OFF_AT_RESET = 1'b0
) (
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire gpdp_pkg::gpdp_axil_req_t I_AXI,
    output gpdp_pkg::gpdp_axil_rsp_t O_AXI,
    input wire logic I_PROTECTED_WRITE_ENABLE,
    input wire logic [gpdp_pkg::PA_W-1:0] I_PA_PIN,
    input wire logic [gpdp_pkg::PB_PINNED-1:0] I_PB_PIN,
    input wire logic I_PB_INT_IN,
    input wire logic [gpdp_pkg::PA_W-1:0] I_PA_GPIO_SEL,
    input wire logic [gpdp_pkg::PA_W-1:0] I_PORT_A_DIRECTION,
    input wire logic [gpdp_pkg::PB_W-1:0] I_PB_GPIO_SEL,
    input wire logic [gpdp_pkg::PB_W-1:0] I_PORT_B_DIRECTION,
    input wire logic [gpdp_pkg::PA_W-1:0] I_PORT_A_BIT_SET,
    input wire logic [gpdp_pkg::PA_W-1:0] I_PORT_A_BIT_CLEAR,
    input wire logic [gpdp_pkg::PA_W-1:0] I_PORT_A_BIT_INVERT,
    input wire logic [gpdp_pkg::PB_W-1:0] I_PORT_B_BIT_SET,
    input wire logic [gpdp_pkg::PB_W-1:0] I_PORT_B_BIT_CLEAR,
    input wire logic [gpdp_pkg::PB_W-1:0] I_PORT_B_BIT_INVERT,
    output logic [gpdp_pkg::PA_W-1:0] O_PA_PIN,
    output logic [gpdp_pkg::PA_W-1:0] O_PA_PIN_OE,
    output logic [gpdp_pkg::PB_PINNED-1:0] O_PB_PIN,
    output logic [gpdp_pkg::PB_PINNED-1:0] O_PB_PIN_OE,
    output logic O_PB_INT_OUT,
    output logic O_PB_INT_OE,
    output logic [gpdp_pkg::PB_W-1:0] O_PB_PULLUP_EN,
    output logic [gpdp_pkg::PA_HI_W-1:0] O_PA_HI_PULLUP_EN
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    // Upper port A pull-up reset depends on the variant
    localparam logic [gpdp_pkg::PA_HI_W-1:0] RST_PA_HI_PUD =
        PA_HI_PULLUP_OFF_AT_RESET ? gpdp_pkg::RST_PA_HI_PUD_OFF : gpdp_pkg::RST_PA_HI_PUD_ON;

    // Bus side
    gpdp_pkg::gpdp_regwr_t wr;
    gpdp_pkg::gpdp_reg_t wr_reg;
    gpdp_pkg::gpdp_reg_t rd_reg;
    logic wr_ok;
    logic rd_ok;
    logic [31:0] rd_data;

    // Pin levels in the clock domain
    logic [gpdp_pkg::PA_W-1:0] pa_level;
    logic [gpdp_pkg::PB_PINNED-1:0] pb_pin_level;
    logic [gpdp_pkg::PB_W-1:0] pb_level;

    // Registered state
    logic [gpdp_pkg::PA_W-1:0] pa_latch;
    logic [gpdp_pkg::PB_W-1:0] pb_latch;
    logic [gpdp_pkg::PB_W-1:0] pb_pud;
    logic [gpdp_pkg::PA_HI_W-1:0] pa_hi_pud;
    logic [gpdp_pkg::PA_W-1:0] pa_oe;
    logic [gpdp_pkg::PB_W-1:0] pb_oe;

    // Next values
    logic [gpdp_pkg::PA_W-1:0] next_pa_latch;
    logic [gpdp_pkg::PB_W-1:0] next_pb_latch;
    logic [gpdp_pkg::PB_W-1:0] next_pb_pud;
    logic [gpdp_pkg::PA_HI_W-1:0] next_pa_hi_pud;
    logic [gpdp_pkg::PA_W-1:0] next_pa_oe;
    logic [gpdp_pkg::PB_W-1:0] next_pb_oe;

    ////////////////////////////////////////////////////////////////////////////
    // Bus front end

    // Read data is taken at the edge the address is accepted
    gpdp_axil_slave u_bus (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .i_req(I_AXI),
        .o_rsp(O_AXI),
        .o_wr(wr),
        .i_wr_ok(wr_ok),
        .i_rd_data(rd_data),
        .i_rd_ok(rd_ok)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin level capture

    // Pins are asynchronous to the bus clock, so reads see them two edges late
    gpdp_sync #(
        .W(gpdp_pkg::PA_W)
    ) u_sync_pa (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .i_d(I_PA_PIN),
        .o_q(pa_level)
    );

    // Only the three pinned port B signals
    gpdp_sync #(
        .W(gpdp_pkg::PB_PINNED)
    ) u_sync_pb (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .i_d(I_PB_PIN),
        .o_q(pb_pin_level)
    );

    // Internal-only signal comes from same-clock logic, no synchroniser needed
    always_comb begin
        pb_level = {I_PB_INT_IN, pb_pin_level};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and read path

    // Write side uses the held address
    always_comb begin
        wr_reg = gpdp_pkg::decode(wr.addr);
        wr_ok = (wr_reg != gpdp_pkg::REG_NONE);
    end

    // Read side decodes the live address
    always_comb begin
        rd_reg = gpdp_pkg::decode(I_AXI.araddr);
        rd_ok = (rd_reg != gpdp_pkg::REG_NONE);
    end

    // Data reads show pin levels; the latch itself is never readable here
    always_comb begin
        // Reserved and unmapped bits stay zero
        rd_data = 32'h0000_0000;
        unique case (rd_reg)
            gpdp_pkg::REG_PA_DAT: begin
                rd_data = pa_level;
            end
            gpdp_pkg::REG_PB_DAT: begin
                rd_data[gpdp_pkg::PB_W-1:0] = pb_level;
            end
            gpdp_pkg::REG_PB_PUD: begin
                rd_data[gpdp_pkg::PB_W-1:0] = pb_pud;
            end
            gpdp_pkg::REG_PA_PUD_HI: begin
                // Disables sit at the pins' own bit positions
                rd_data[gpdp_pkg::PA_HI_LSB +: gpdp_pkg::PA_HI_W] = pa_hi_pud;
            end
            gpdp_pkg::REG_NONE: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output latches

    // Bus write loads first, then set, clear and invert act on the result,
    // so a strobe in the same cycle as a data write is never lost
    always_comb begin
        next_pa_latch = pa_latch;
        if (wr.en && wr_reg == gpdp_pkg::REG_PA_DAT) begin
            next_pa_latch = gpdp_pkg::apply_strb(pa_latch, wr.data, wr.strb);
        end
        next_pa_latch = ((next_pa_latch | I_PORT_A_BIT_SET) & ~I_PORT_A_BIT_CLEAR) ^ I_PORT_A_BIT_INVERT;
        if (I_SYS_RST) begin
            next_pa_latch = gpdp_pkg::RST_PA_LATCH;
        end
    end

    // Port B rides the low byte lane
    always_comb begin
        logic [31:0] pb_word;
        pb_word = 32'h0000_0000;
        next_pb_latch = pb_latch;
        if (wr.en && wr_reg == gpdp_pkg::REG_PB_DAT) begin
            pb_word = gpdp_pkg::apply_strb({28'h000_0000, pb_latch}, wr.data, wr.strb);
            next_pb_latch = pb_word[gpdp_pkg::PB_W-1:0];
        end
        next_pb_latch = ((next_pb_latch | I_PORT_B_BIT_SET) & ~I_PORT_B_BIT_CLEAR) ^ I_PORT_B_BIT_INVERT;
        if (I_SYS_RST) begin
            next_pb_latch = gpdp_pkg::RST_PB_LATCH;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        pa_latch <= next_pa_latch;
    end

    always_ff @(posedge I_SYS_CLK) begin
        pb_latch <= next_pb_latch;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pull-up disable registers

    // Protected set: writes without the enable are dropped but still answered OKAY
    always_comb begin
        next_pb_pud = pb_pud;
        if (wr.en && I_PROTECTED_WRITE_ENABLE) begin
            if (wr_reg == gpdp_pkg::REG_PB_PUD && wr.strb[0]) begin
                // Bits above the four signals are not stored
                next_pb_pud = wr.data[gpdp_pkg::PB_W-1:0];
            end
        end
        if (I_SYS_RST) begin
            next_pb_pud = gpdp_pkg::RST_PB_PUD;
        end
    end

    // Port A pins 12..15
    always_comb begin
        next_pa_hi_pud = pa_hi_pud;
        if (wr.en && I_PROTECTED_WRITE_ENABLE) begin
            if (wr_reg == gpdp_pkg::REG_PA_PUD_HI && wr.strb[1]) begin
                next_pa_hi_pud = wr.data[gpdp_pkg::PA_HI_LSB +: gpdp_pkg::PA_HI_W];
            end
        end
        if (I_SYS_RST) begin
            next_pa_hi_pud = RST_PA_HI_PUD;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        pb_pud <= next_pb_pud;
    end

    always_ff @(posedge I_SYS_CLK) begin
        pa_hi_pud <= next_pa_hi_pud;
    end

    // Internal signal leaks in low power until software clears its bit
    always_comb begin
        O_PB_PULLUP_EN = ~pb_pud;
    end

    // Same active-high sense for port A
    always_comb begin
        O_PA_HI_PULLUP_EN = ~pa_hi_pud;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive

    // Enables are registered so they move in step with the latch
    always_comb begin
        next_pa_oe = I_PA_GPIO_SEL & I_PORT_A_DIRECTION;
        if (I_SYS_RST) begin
            next_pa_oe = '0;
        end
    end

    always_comb begin
        next_pb_oe = I_PB_GPIO_SEL & I_PORT_B_DIRECTION;
        if (I_SYS_RST) begin
            next_pb_oe = '0;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        pa_oe <= next_pa_oe;
    end

    always_ff @(posedge I_SYS_CLK) begin
        pb_oe <= next_pb_oe;
    end

    always_comb begin
        O_PA_PIN = pa_latch;
        O_PA_PIN_OE = pa_oe;
    end

    // Bit 3 has no pin, so it leaves on ports of its own
    always_comb begin
        O_PB_PIN = pb_latch[gpdp_pkg::PB_PINNED-1:0];
        O_PB_PIN_OE = pb_oe[gpdp_pkg::PB_PINNED-1:0];
        O_PB_INT_OUT = pb_latch[gpdp_pkg::PB_W-1];
        O_PB_INT_OE = pb_oe[gpdp_pkg::PB_W-1];
    end

endmodule // gpdp_top

`default_nettype wire

// *** verilog/gpdp_pkg.sv ***
// Shared constants, types and helpers of the GPIO port data and pull-up block.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
`default_nettype none

package gpdp_pkg;

    localparam int PA_W = 32;
    localparam int PB_W = 4;
    localparam int PB_PINNED = 3;
    localparam int PA_HI_LSB = 12;
    localparam int PA_HI_W = 4;

    // Byte addresses of the registers
    localparam logic [31:0] OFS_PORT_A_PIN_DATA = 32'h0000_0000;
    localparam logic [31:0] OFS_PORT_B_PIN_DATA = 32'h0000_0004;
    localparam logic [31:0] OFS_PORT_B_PULLUP_DISABLE = 32'h0000_0008;
    localparam logic [31:0] OFS_PORT_A_PULLUP_DISABLE_HI = 32'h0000_000C;

    // Reset values
    localparam logic [PA_W-1:0] RST_PA_LATCH = 32'h0000_0000;
    localparam logic [PB_W-1:0] RST_PB_LATCH = 4'h0;
    localparam logic [PB_W-1:0] RST_PB_PUD = 4'h8;
    localparam logic [PA_HI_W-1:0] RST_PA_HI_PUD_ON = 4'h0;
    localparam logic [PA_HI_W-1:0] RST_PA_HI_PUD_OFF = 4'hF;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {REG_PA_DAT, REG_PB_DAT, REG_PB_PUD, REG_PA_PUD_HI, REG_NONE} gpdp_reg_t;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } gpdp_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } gpdp_axil_rsp_t;

    typedef struct packed {
        logic en;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } gpdp_regwr_t;

    function automatic gpdp_reg_t decode(input logic [31:0] addr);
        case ({addr[31:2], 2'h0})
            OFS_PORT_A_PIN_DATA: decode = REG_PA_DAT;
            OFS_PORT_B_PIN_DATA: decode = REG_PB_DAT;
            OFS_PORT_B_PULLUP_DISABLE: decode = REG_PB_PUD;
            OFS_PORT_A_PULLUP_DISABLE_HI: decode = REG_PA_PUD_HI;
            default: decode = REG_NONE;
        endcase
    endfunction

    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

`default_nettype wire

// *** verilog/gpdp_sync.sv ***
// Two-flop synchroniser for pin levels entering the system clock domain.
// Assumes levels only; no pulse is narrower than a few clock periods.
`timescale 1ns/10ps
`default_nettype none

module gpdp_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = i_rst ? '0 : i_d;
        next_q = i_rst ? '0 : meta;
    end

    always_ff @(posedge i_clk) begin
        meta <= next_meta;
        o_q <= next_q;
    end

endmodule // gpdp_sync

`default_nettype wire

// *** verilog/gpdp_axil_slave.sv ***
// AXI4-Lite slave front end: holds address and data, issues one register write pulse.
// Assumes the register decode answers within the same cycle.
`timescale 1ns/10ps
`default_nettype none

module gpdp_axil_slave (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire gpdp_pkg::gpdp_axil_req_t i_req,
    output gpdp_pkg::gpdp_axil_rsp_t o_rsp,
    output gpdp_pkg::gpdp_regwr_t o_wr,
    input wire logic i_wr_ok,
    input wire logic [31:0] i_rd_data,
    input wire logic i_rd_ok
);

    logic aw_held, w_held, bvalid, rvalid;
    logic [31:0] aw_addr, w_data, rdata;
    logic [3:0] w_strb;
    logic [1:0] bresp, rresp;
    logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
    logic [31:0] next_aw_addr, next_w_data, next_rdata;
    logic [3:0] next_w_strb;
    logic [1:0] next_bresp, next_rresp;
    logic aw_fire, w_fire, ar_fire;

    always_comb begin
        o_rsp.awready = !aw_held && !bvalid;
        o_rsp.wready = !w_held && !bvalid;
        o_rsp.arready = !rvalid;
        o_rsp.bvalid = bvalid;
        o_rsp.bresp = bresp;
        o_rsp.rvalid = rvalid;
        o_rsp.rdata = rdata;
        o_rsp.rresp = rresp;
        // Both halves must be held before the write is issued
        o_wr.en = aw_held && w_held && !bvalid;
        o_wr.addr = aw_addr;
        o_wr.data = w_data;
        o_wr.strb = w_strb;
        aw_fire = i_req.awvalid && o_rsp.awready;
        w_fire = i_req.wvalid && o_rsp.wready;
        ar_fire = i_req.arvalid && o_rsp.arready;
        next_aw_held = aw_fire || (aw_held && !o_wr.en);
        next_w_held = w_fire || (w_held && !o_wr.en);
        next_aw_addr = aw_fire ? i_req.awaddr : aw_addr;
        next_w_data = w_fire ? i_req.wdata : w_data;
        next_w_strb = w_fire ? i_req.wstrb : w_strb;
        next_bvalid = o_wr.en || (bvalid && !i_req.bready);
        next_bresp = o_wr.en ? (i_wr_ok ? gpdp_pkg::RESP_OKAY : gpdp_pkg::RESP_SLVERR) : bresp;
        next_rvalid = ar_fire || (rvalid && !i_req.rready);
        next_rdata = ar_fire ? i_rd_data : rdata;
        next_rresp = ar_fire ? (i_rd_ok ? gpdp_pkg::RESP_OKAY : gpdp_pkg::RESP_SLVERR) : rresp;
        if (i_rst) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b0;
            next_rvalid = 1'b0;
            next_rdata = 32'h0000_0000;
            next_bresp = gpdp_pkg::RESP_OKAY;
            next_rresp = gpdp_pkg::RESP_OKAY;
        end
    end

    always_ff @(posedge i_clk) begin
        aw_held <= next_aw_held;
        w_held <= next_w_held;
        aw_addr <= next_aw_addr;
        w_data <= next_w_data;
        w_strb <= next_w_strb;
        bvalid <= next_bvalid;
        bresp <= next_bresp;
        rvalid <= next_rvalid;
        rdata <= next_rdata;
        rresp <= next_rresp;
    end

endmodule // gpdp_axil_slave

`default_nettype wire

// *** testbench/gpdp_pin_model.sv ***
// Behavioural model of the pins beyond the port data block.
// Assumes bench-chosen levels stand for external drivers on undriven pins.
`timescale 1ns/10ps
`default_nettype none
module gpdp_pin_model (
    input wire logic i_clk,
    input wire logic [31:0] i_pa_drv,
    input wire logic [31:0] i_pa_oe,
    input wire logic [3:0] i_pb_drv,
    input wire logic [3:0] i_pb_oe,
    input wire logic [3:0] i_pb_pu,
    input wire logic [31:0] i_pa_ext,
    input wire logic [2:0] i_pb_ext,
    output logic [31:0] o_pa_pin,
    output logic [2:0] o_pb_pin,
    output logic o_int_in
);
    logic flip = 1'b0;
    // A floating net must not keep its last level
    always @(posedge i_clk) begin
        flip <= ~flip;
    end
    assign o_pa_pin = (i_pa_oe & i_pa_drv) | (~i_pa_oe & i_pa_ext);
    assign o_pb_pin = (i_pb_oe[2:0] & i_pb_drv[2:0]) | (~i_pb_oe[2:0] & i_pb_ext);
    // No package pin: only the design or the pull-up sets this net
    assign o_int_in = i_pb_oe[3] ? i_pb_drv[3] : (i_pb_pu[3] ? 1'b1 : flip);
endmodule // gpdp_pin_model
`default_nettype wire

// *** testbench/gpdp_top_assertions.sv ***
// Concurrent checks on the ports of the port data and pull-up block.
// Assumes a single clock with synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module gpdp_chk #(
    parameter bit PA_HI_PULLUP_OFF_AT_RESET = 1'b0
) (
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire gpdp_pkg::gpdp_axil_req_t I_AXI,
    input wire gpdp_pkg::gpdp_axil_rsp_t O_AXI,
    input wire logic I_PROTECTED_WRITE_ENABLE,
    input wire logic I_PB_INT_IN,
    input wire logic [31:0] I_PA_GPIO_SEL,
    input wire logic [31:0] I_PORT_A_DIRECTION,
    input wire logic [3:0] I_PB_GPIO_SEL,
    input wire logic [3:0] I_PORT_B_DIRECTION,
    input wire logic [31:0] I_PORT_A_BIT_SET,
    input wire logic [31:0] I_PORT_A_BIT_CLEAR,
    input wire logic [31:0] I_PORT_A_BIT_INVERT,
    input wire logic [31:0] O_PA_PIN,
    input wire logic [31:0] O_PA_PIN_OE,
    input wire logic [2:0] O_PB_PIN_OE,
    input wire logic O_PB_INT_OE,
    input wire logic [3:0] O_PB_PULLUP_EN,
    input wire logic [3:0] O_PA_HI_PULLUP_EN
);
    logic [31:0] rd_addr;
    // Address of the read in flight, for judging its data
    always_ff @(posedge I_SYS_CLK) begin
        if (I_AXI.arvalid && O_AXI.arready) begin
            rd_addr <= I_AXI.araddr;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);
    a_pud_reset_val: assert property ($past(I_SYS_RST) |-> O_PB_PULLUP_EN == 4'h7 &&
        O_PA_HI_PULLUP_EN == (PA_HI_PULLUP_OFF_AT_RESET ? 4'h0 : 4'hF)) else $error("pull-up reset value wrong");
    a_latch_reset: assert property ($past(I_SYS_RST) |-> O_PA_PIN == 32'h0 && O_PA_PIN_OE == 32'h0)
        else $error("latch not cleared by reset");
    a_pa_oe_sel: assert property (!$past(I_SYS_RST) |->
        O_PA_PIN_OE == ($past(I_PA_GPIO_SEL) & $past(I_PORT_A_DIRECTION))) else $error("port A drive enable wrong");
    a_pb_oe_sel: assert property (!$past(I_SYS_RST) |->
        {O_PB_INT_OE, O_PB_PIN_OE} == ($past(I_PB_GPIO_SEL) & $past(I_PORT_B_DIRECTION))) else $error("port B oe");
    a_pud_protect: assert property (!$stable(O_PB_PULLUP_EN) && !$past(I_SYS_RST) |->
        $past(I_PROTECTED_WRITE_ENABLE) || $past(I_PROTECTED_WRITE_ENABLE, 2)) else $error("unprotected pull-up write");
    a_latch_hold: assert property (!$stable(O_PA_PIN) && !$past(I_SYS_RST) |-> $rose(O_AXI.bvalid) ||
        ($past(I_PORT_A_BIT_SET) | $past(I_PORT_A_BIT_CLEAR) | $past(I_PORT_A_BIT_INVERT)) != 32'h0)
        else $error("latch changed without a write");
    a_pb_rd_zero: assert property ($rose(O_AXI.rvalid) && (rd_addr == gpdp_pkg::OFS_PORT_B_PIN_DATA ||
        rd_addr == gpdp_pkg::OFS_PORT_B_PULLUP_DISABLE) |-> O_AXI.rdata[31:4] == 28'h0) else $error("reserved bits set");
    a_int_rd_level: assert property ($rose(O_AXI.rvalid) && rd_addr == gpdp_pkg::OFS_PORT_B_PIN_DATA |->
        O_AXI.rdata[3] == $past(I_PB_INT_IN)) else $error("internal signal read wrong");
    a_pud_inverse: assert property ($rose(O_AXI.rvalid) && rd_addr == gpdp_pkg::OFS_PORT_B_PULLUP_DISABLE |->
        O_AXI.rdata[3:0] == ~O_PB_PULLUP_EN) else $error("pull-up enable not inverse of disable");
    c_pud_change: cover property (!$stable(O_PB_PULLUP_EN));
    c_strobe: cover property (I_PORT_A_BIT_INVERT != 32'h0);
    c_slverr: cover property (O_AXI.rvalid && O_AXI.rresp == gpdp_pkg::RESP_SLVERR);
endmodule // gpdp_chk
bind gpdp_top gpdp_chk #(.PA_HI_PULLUP_OFF_AT_RESET(PA_HI_PULLUP_OFF_AT_RESET)) u_chk (.I_SYS_CLK, .I_SYS_RST,
    .I_AXI, .O_AXI, .I_PROTECTED_WRITE_ENABLE, .I_PB_INT_IN, .I_PA_GPIO_SEL, .I_PORT_A_DIRECTION, .I_PB_GPIO_SEL,
    .I_PORT_B_DIRECTION, .I_PORT_A_BIT_SET, .I_PORT_A_BIT_CLEAR, .I_PORT_A_BIT_INVERT, .O_PA_PIN, .O_PA_PIN_OE,
    .O_PB_PIN_OE, .O_PB_INT_OE, .O_PB_PULLUP_EN, .O_PA_HI_PULLUP_EN);
`default_nettype wire

// *** testbench/tb_gpio_port_data_and_pullup.sv ***
// Self-checking bench for the port data and pull-up block.
// Assumes the pin model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module tb_gpio_port_data_and_pullup;
    localparam logic [31:0] PA = gpdp_pkg::OFS_PORT_A_PIN_DATA;
    localparam logic [31:0] PB = gpdp_pkg::OFS_PORT_B_PIN_DATA;
    localparam logic [31:0] PU = gpdp_pkg::OFS_PORT_B_PULLUP_DISABLE;
    localparam logic [31:0] PH = gpdp_pkg::OFS_PORT_A_PULLUP_DISABLE_HI;
    localparam logic [1:0] OK = gpdp_pkg::RESP_OKAY;
    localparam logic [31:0] S = 32'h0000_00FF, C = 32'h0000_F00F, T = 32'h0F0F_0F0F;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pwe = 1'b0;
    gpdp_pkg::gpdp_axil_req_t axi = '0;
    gpdp_pkg::gpdp_axil_rsp_t rsp;
    logic [31:0] a_ext = '0, a_sel = '0, a_dir = '0, a_set = '0, a_clr = '0, a_inv = '0;
    logic [3:0] b_sel = '0, b_dir = '0, b_set = '0, b_clr = '0, b_inv = '0;
    logic [2:0] b_ext = '0;
    logic [31:0] a_pin, a_out, a_oe, d, lat;
    logic [2:0] b_pin, b_out, b_oe;
    logic i_in, i_out, i_oe;
    logic [3:0] b_pu, a_pu, bd;
    int n_mismatch = 0;
    int comparisons = 0;
    int seed = 32'hfb5869f5;
    always #50 clk = ~clk;
    gpdp_top dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_AXI(axi), .O_AXI(rsp), .I_PROTECTED_WRITE_ENABLE(pwe),
        .I_PA_PIN(a_pin), .I_PB_PIN(b_pin), .I_PB_INT_IN(i_in), .I_PA_GPIO_SEL(a_sel), .I_PORT_A_DIRECTION(a_dir),
        .I_PB_GPIO_SEL(b_sel), .I_PORT_B_DIRECTION(b_dir), .I_PORT_A_BIT_SET(a_set), .I_PORT_A_BIT_CLEAR(a_clr),
        .I_PORT_A_BIT_INVERT(a_inv), .I_PORT_B_BIT_SET(b_set), .I_PORT_B_BIT_CLEAR(b_clr),
        .I_PORT_B_BIT_INVERT(b_inv), .O_PA_PIN(a_out), .O_PA_PIN_OE(a_oe), .O_PB_PIN(b_out), .O_PB_PIN_OE(b_oe),
        .O_PB_INT_OUT(i_out), .O_PB_INT_OE(i_oe), .O_PB_PULLUP_EN(b_pu), .O_PA_HI_PULLUP_EN(a_pu));
    gpdp_pin_model pins (.i_clk(clk), .i_pa_drv(a_out), .i_pa_oe(a_oe), .i_pb_drv({i_out, b_out}),
        .i_pb_oe({i_oe, b_oe}), .i_pb_pu(b_pu), .i_pa_ext(a_ext), .i_pb_ext(b_ext), .o_pa_pin(a_pin),
        .o_pb_pin(b_pin), .o_int_in(i_in));
    logic [3:0] a_pu_v;
    // Variant whose port A pins 12..15 leave reset with pull-ups off
    gpdp_top #(.PA_HI_PULLUP_OFF_AT_RESET(1'b1)) dut_v (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_AXI(axi),
        .O_AXI(), .I_PROTECTED_WRITE_ENABLE(pwe), .I_PA_PIN(a_pin), .I_PB_PIN(b_pin), .I_PB_INT_IN(i_in),
        .I_PA_GPIO_SEL(a_sel), .I_PORT_A_DIRECTION(a_dir), .I_PB_GPIO_SEL(b_sel), .I_PORT_B_DIRECTION(b_dir),
        .I_PORT_A_BIT_SET(a_set), .I_PORT_A_BIT_CLEAR(a_clr), .I_PORT_A_BIT_INVERT(a_inv),
        .I_PORT_B_BIT_SET(b_set), .I_PORT_B_BIT_CLEAR(b_clr), .I_PORT_B_BIT_INVERT(b_inv), .O_PA_PIN(),
        .O_PA_PIN_OE(), .O_PB_PIN(), .O_PB_PIN_OE(), .O_PB_INT_OUT(), .O_PB_INT_OE(), .O_PB_PULLUP_EN(),
        .O_PA_HI_PULLUP_EN(a_pu_v));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] pin_lvl(input logic [31:0] oe, input logic [31:0] drv, input logic [31:0] ext);
        return (oe & drv) | (~oe & ext);
    endfunction
    function automatic logic [31:0] strobe(input logic [31:0] l, input logic [31:0] s, input logic [31:0] c,
                                           input logic [31:0] t);
        return ((l | s) & ~c) ^ t;
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_rsp(input logic [1:0] g, input logic [1:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Trailing idle edge keeps a following call from driving the same signal twice
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
        int t;
        logic done;
        axi.awaddr <= a;
        axi.wdata <= v;
        axi.wstrb <= s;
        axi.awvalid <= 1'b1;
        axi.wvalid <= 1'b1;
        axi.bready <= 1'b1;
        t = 0;
        done = 1'b0;
        while (!done && t < 50) begin
            @(posedge clk);
            t++;
            if (axi.awvalid && rsp.awready) axi.awvalid <= 1'b0;
            if (axi.wvalid && rsp.wready) axi.wvalid <= 1'b0;
            done = rsp.bvalid === 1'b1;
        end
        axi.bready <= 1'b0;
        cmp_rsp(rsp.bresp, OK);
        if (!done) n_mismatch++;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        int t;
        logic done;
        axi.araddr <= a;
        axi.arvalid <= 1'b1;
        axi.rready <= 1'b1;
        t = 0;
        done = 1'b0;
        while (!done && t < 50) begin
            @(posedge clk);
            t++;
            if (axi.arvalid && rsp.arready) axi.arvalid <= 1'b0;
            done = rsp.rvalid === 1'b1;
        end
        axi.rready <= 1'b0;
        cmp(rsp.rdata, e);
        cmp_rsp(rsp.rresp, er);
        if (!done) n_mismatch++;
        @(posedge clk);
    endtask
    task automatic end_of_test;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        a_ext <= $random(seed);
        repeat (4) @(posedge clk);
        #1;
        cmp({28'h0, b_pu}, 32'h7);
        cmp({28'h0, a_pu}, 32'hF);
        cmp({28'h0, a_pu_v}, 32'h0);
        cmp(a_out, 32'h0);
        rd_chk(PA, a_ext, OK);
        rd_chk(PU, 32'h8, OK);
        axi_wr(PU, 32'h0, 4'hF);
        rd_chk(PU, 32'h8, OK);
        pwe <= 1'b1;
        axi_wr(PU, 32'hFFFF_FFD0, 4'hF);
        rd_chk(PU, 32'h0, OK);
        cmp({28'h0, b_pu}, 32'hF);
        axi_wr(PU, 32'h5, 4'hF);
        axi_wr(PH, 32'h5000, 4'h2);
        pwe <= 1'b0;
        cmp({28'h0, b_pu}, 32'hA);
        cmp({28'h0, a_pu}, 32'hA);
        rd_chk(32'h10, 32'h0, gpdp_pkg::RESP_SLVERR);
        for (int i = 0; i < 24; i++) begin
            d = $random(seed);
            bd = 4'($random(seed));
            a_ext <= $random(seed);
            b_ext <= 3'($random(seed));
            a_sel <= (i == 0) ? 32'hFFFF_FFFF : $random(seed);
            a_dir <= (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : $random(seed);
            b_sel <= 4'($random(seed));
            b_dir <= 4'($random(seed));
            axi_wr(PA, d, 4'hF);
            axi_wr(PB, {28'h0, bd}, 4'hF);
            repeat (4) @(posedge clk);
            #1;
            cmp(a_out, d);
            cmp({28'h0, i_out, b_out}, {28'h0, bd});
            cmp(a_oe, a_sel & a_dir);
            cmp({28'h0, i_oe, b_oe}, {28'h0, b_sel & b_dir});
            rd_chk(PA, pin_lvl(a_sel & a_dir, d, a_ext), OK);
            rd_chk(PB, pin_lvl({28'h0, b_sel & b_dir}, {28'h0, bd}, {28'h0, 1'b1, b_ext}), OK);
        end
        lat = d;
        lat[15:8] = 8'hA5;
        axi_wr(PA, 32'hA5A5_A5A5, 4'h2);
        {a_set, a_clr, a_inv} <= {S, C, T};
        {b_set, b_clr, b_inv} <= {4'h3, 4'h5, 4'h6};
        @(posedge clk);
        {a_set, a_clr, a_inv} <= '0;
        {b_set, b_clr, b_inv} <= '0;
        repeat (2) @(posedge clk);
        #1;
        cmp(a_out, strobe(lat, S, C, T));
        cmp({28'h0, i_out, b_out}, strobe({28'h0, bd}, 32'h3, 32'h5, 32'h6));
        end_of_test;
    end
endmodule // tb_gpio_port_data_and_pullup
`default_nettype wire
